// File: src/emb_pkg.sv
package emb_pkg;
  // Bus and array geometry.
  localparam int EMB_DW        = 32;
  localparam int EMB_AW        = 6;
  localparam int EMB_RAM_BITS  = 4096;
  localparam int EMB_RAM_WORDS = 128;
  localparam int EMB_RAM_AW    = 12;
  localparam int EMB_CAM_DEPTH = 32;
  localparam int EMB_CAM_IW    = 5;
  localparam int EMB_LINES     = 16;
  localparam logic [2:0] EMB_WC_MAX       = 3'h5;
  localparam logic [2:0] EMB_WC_MAX_SPLIT = 3'h4;

  // Register byte offsets.
  localparam logic [EMB_AW-1:0] EMB_OFF_CTRL      = 6'h00;
  localparam logic [EMB_AW-1:0] EMB_OFF_STATUS    = 6'h04;
  localparam logic [EMB_AW-1:0] EMB_OFF_RAM_ADDR  = 6'h08;
  localparam logic [EMB_AW-1:0] EMB_OFF_RAM_DATA  = 6'h0C;
  localparam logic [EMB_AW-1:0] EMB_OFF_CAM_INDEX = 6'h10;
  localparam logic [EMB_AW-1:0] EMB_OFF_CAM_MASK  = 6'h14;
  localparam logic [EMB_AW-1:0] EMB_OFF_CAM_DATA  = 6'h18;
  localparam logic [EMB_AW-1:0] EMB_OFF_CAM_KEY   = 6'h1C;
  localparam logic [EMB_AW-1:0] EMB_OFF_CAM_LINES = 6'h20;

  // Control fields.
  localparam int EMB_CTRL_SPLIT   = 0;
  localparam int EMB_CTRL_WC_LSB  = 1;
  localparam int EMB_CTRL_MODE_LSB = 4;
  localparam int EMB_CTRL_UNENC   = 6;
  localparam int EMB_CTRL_ROM     = 7;
  localparam int EMB_CTRL_FREEZE  = 8;
  localparam int EMB_CTRL_W       = 9;
  localparam logic [EMB_CTRL_W-1:0] EMB_CTRL_RST = 9'h000;
  localparam int EMB_RADDR_HALF   = 12;

  // Status fields.
  localparam int EMB_ST_FLAG  = 8;
  localparam int EMB_ST_VALID = 9;
  localparam int EMB_ST_PHASE = 10;
  localparam int EMB_ST_SEL   = 11;

  // Wait cycles per access kind.
  localparam logic [1:0] EMB_LAT_NONE      = 2'h0;
  localparam logic [1:0] EMB_LAT_RAM_RD    = 2'h1;
  localparam logic [1:0] EMB_LAT_CAM_WR    = 2'h2;
  localparam logic [1:0] EMB_LAT_CAM_WR_DC = 2'h3;
  localparam logic [1:0] EMB_LAT_LOOK      = 2'h1;
  localparam logic [1:0] EMB_LAT_LOOK_2P   = 2'h2;

  localparam logic [15:0] EMB_ODD_LINES  = 16'hAAAA;
  localparam logic [15:0] EMB_EVEN_LINES = 16'h5555;

  typedef enum logic [1:0] {
    EMB_SINGLE, EMB_MULTI, EMB_FAST, EMB_MODE_RSVD
  } emb_cam_mode_t;

  typedef enum logic [2:0] {
    EMB_ACC_NONE, EMB_ACC_REG, EMB_ACC_RAM_RD, EMB_ACC_RAM_WR,
    EMB_ACC_CAM_WR, EMB_ACC_LOOKUP
  } emb_acc_t;
endpackage : emb_pkg

// File: src/emb_cam_match.sv
`timescale 1ns/10ps
module emb_cam_match
  import emb_pkg::*;
#(
  parameter int DEPTH = EMB_CAM_DEPTH,
  parameter int WIDTH = EMB_DW
)(
  input  wire logic [DEPTH-1:0][WIDTH-1:0] keys,
  input  wire logic [DEPTH-1:0][WIDTH-1:0] cares,
  input  wire logic [DEPTH-1:0]            valid,
  input  wire logic [WIDTH-1:0]            key,
  input  wire logic                        ignore_msb,
  output logic      [DEPTH-1:0]            hit
);
  logic [WIDTH-1:0] cmp_mask;

  // The top bit becomes a bank select and leaves the compare.
  assign cmp_mask = ignore_msb ? {1'b0, {(WIDTH-1){1'b1}}} : '1;

  // Every entry compares at once; a cleared care bit never blocks.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_cmp
      assign hit[i] = valid[i] &&
        (((keys[i] ^ key) & cares[i] & cmp_mask) == '0);
    end
  endgenerate
endmodule : emb_cam_match

// File: src/emb_memory_block.sv
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - Block splits into two single-port RAMs.
// - Single RAM shapes 4096x1 down to 128x32.
// - Every register clears asynchronously on any clear.
// - CAM returns stored address, searching in parallel.
// - Match flag high when any entry matches; fast mode counts entries 0-15 only.
// - CAM holds 32 entries of 32 bits.
// - Don't-care bits never block a match.
// - Three output modes, encoded or unencoded.
// - Encoded result is the binary location; multiple and fast modes give 0.
// - Unencoded gives 16 one-hot lines, two cycles except in fast mode.
// - Unencoded compares 31 bits; top bit selects.
// - Select 1 odd words, 0 even words.
// - Single mode: write two cycles, lookup one encoded, two unencoded.
// - Multiple mode: 16 lines per cycle, two cycles.
// - Fast mode: one cycle, at most 16 words.
// - CAM loads at configuration or at run time.
// - Don't-care write needs a third cycle.
// - Input and output registers placed independently; here only the output stage is optional, through OUT_REG.
// - Input and output registers use separate enables.
// - Preloaded block acts as read-only table.
module emb_memory_block
  import emb_pkg::*;
#(
  parameter logic [EMB_RAM_BITS-1:0] RAM_INIT = '0,
  parameter logic [EMB_CAM_DEPTH-1:0][EMB_DW-1:0] CAM_INIT_KEY = '0,
  parameter logic [EMB_CAM_DEPTH-1:0] CAM_INIT_VALID = '0,
  parameter bit OUT_REG = 1'b1
)(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 clr_local,
  input  wire logic                 clr_global,
  input  wire logic [EMB_AW-1:0]    avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [EMB_DW-1:0]    avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [EMB_DW-1:0]    avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      match_flag,
  output logic      [EMB_CAM_IW-1:0] match_addr,
  output logic      [EMB_LINES-1:0] match_lines,
  output logic                      result_valid
);
  // Byte-lane merge for plain register writes.
  function automatic logic [31:0] emb_be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : emb_be_merge

  function automatic emb_acc_t emb_decode(input logic [EMB_AW-1:0] a,
      input logic wr);
    emb_acc_t k;
    case (a)
      EMB_OFF_RAM_DATA: k = wr ? EMB_ACC_RAM_WR : EMB_ACC_RAM_RD;
      EMB_OFF_CAM_DATA: k = wr ? EMB_ACC_CAM_WR : EMB_ACC_REG;
      EMB_OFF_CAM_KEY:  k = wr ? EMB_ACC_LOOKUP : EMB_ACC_REG;
      default:          k = EMB_ACC_REG;
    endcase
    return k;
  endfunction : emb_decode

  // Lowest matching entry wins the encoded address.
  function automatic logic [4:0] emb_prio(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : emb_prio

  function automatic logic [15:0] emb_bank(input logic [15:0] half,
      input logic unenc, input logic sel);
    return unenc ? (half & (sel ? EMB_ODD_LINES : EMB_EVEN_LINES))
                 : half;
  endfunction : emb_bank

  logic                        arst;
  logic [EMB_CTRL_W-1:0]       ctrl_r;
  logic [12:0]                 ram_addr_r;
  logic [EMB_CAM_IW-1:0]       cam_idx_r;
  logic [31:0]                 cam_mask_r;
  logic [1:0]                  cnt_r;
  logic [1:0]                  lat;
  emb_acc_t                    kind;
  emb_cam_mode_t               mode;
  logic                        req, accept, unenc, split, two_phase;
  logic                        ram_rd_fire, ram_wr_fire, cam_wr_fire;
  logic                        look0, look1, sel, enc_ok;
  logic [2:0]                  wc_eff;
  logic [11:0]                 off;
  logic [31:0]                 lmask, rdata_r, key_r, status;
  logic [EMB_DW-1:0]           ram_r [EMB_RAM_WORDS];
  logic [EMB_CAM_DEPTH-1:0][EMB_DW-1:0] cam_key_r, cam_care_r;
  logic [EMB_CAM_DEPTH-1:0]    cam_valid_r, hit, hit_eff;
  logic                        flag_r, valid_r, phase_r, sel_r;
  logic [EMB_CAM_IW-1:0]       addr_r;
  logic [EMB_LINES-1:0]        lines_r;

  // Chip-wide reset, local and global clears all act without the clock.
  assign arst = rst | clr_local | clr_global;

  assign req   = avs_read | avs_write;
  assign kind  = req ? emb_decode(avs_address, avs_write) : EMB_ACC_NONE;
  assign mode  = emb_cam_mode_t'(ctrl_r[EMB_CTRL_MODE_LSB +: 2]);
  assign unenc = ctrl_r[EMB_CTRL_UNENC];
  assign split = ctrl_r[EMB_CTRL_SPLIT];
  assign sel   = avs_writedata[EMB_DW-1];
  assign enc_ok = (mode == EMB_SINGLE) || (mode == EMB_MODE_RSVD);

  // Two result phases unless the fast mode or encoded single lookup.
  always_comb begin
    case (mode)
      EMB_MULTI: two_phase = 1'b1;
      EMB_FAST:  two_phase = 1'b0;
      default:   two_phase = unenc;
    endcase
  end

  // Wait cycles per access; a masked CAM write takes a third cycle.
  always_comb begin
    case (kind)
      EMB_ACC_RAM_RD: lat = EMB_LAT_RAM_RD;
      EMB_ACC_CAM_WR: lat = (cam_mask_r != '0) ? EMB_LAT_CAM_WR_DC
                                               : EMB_LAT_CAM_WR;
      EMB_ACC_LOOKUP: lat = two_phase ? EMB_LAT_LOOK_2P
                                      : EMB_LAT_LOOK;
      default:        lat = EMB_LAT_NONE;
    endcase
  end

  // A low clock enable also holds the bus, so nothing is lost.
  assign avs_waitrequest = req && (!ce || (cnt_r < lat));
  assign accept      = req && ce && (cnt_r >= lat);
  assign ram_rd_fire = ce && (kind == EMB_ACC_RAM_RD) && (cnt_r == 2'h0);
  assign ram_wr_fire = accept && (kind == EMB_ACC_RAM_WR) &&
                       !ctrl_r[EMB_CTRL_ROM];
  assign cam_wr_fire = ce && (kind == EMB_ACC_CAM_WR) &&
                       (cnt_r == 2'(lat - 2'h1));
  assign look0 = ce && (kind == EMB_ACC_LOOKUP) && (cnt_r == 2'h0);
  assign look1 = ce && (kind == EMB_ACC_LOOKUP) && (cnt_r == 2'h1) &&
                 two_phase;

  // Cycle counter of the access in progress.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      cnt_r <= 2'h0;
    end else if (ce) begin
      if (accept || !req) begin
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= 2'(cnt_r + 2'h1);
      end
    end
  end

  // Plain control registers honour the byte enables.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      ctrl_r     <= EMB_CTRL_RST;
      ram_addr_r <= 13'h0000;
      cam_idx_r  <= 5'h00;
      cam_mask_r <= 32'h00000000;
    end else if (accept && avs_write && (kind == EMB_ACC_REG)) begin
      case (avs_address)
        EMB_OFF_CTRL: ctrl_r <= EMB_CTRL_W'(emb_be_merge(
          32'(ctrl_r), avs_writedata, avs_byteenable));
        EMB_OFF_RAM_ADDR: ram_addr_r <= 13'(emb_be_merge(
          32'(ram_addr_r), avs_writedata, avs_byteenable));
        EMB_OFF_CAM_INDEX: cam_idx_r <= 5'(emb_be_merge(
          32'(cam_idx_r), avs_writedata, avs_byteenable));
        EMB_OFF_CAM_MASK: cam_mask_r <= emb_be_merge(
          cam_mask_r, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // Shape: width 2^wc bits; a split block gives each half 2048 bits.
  always_comb begin
    wc_eff = ctrl_r[EMB_CTRL_WC_LSB +: 3];
    if (split && (wc_eff > EMB_WC_MAX_SPLIT)) begin
      wc_eff = EMB_WC_MAX_SPLIT;
    end else if (wc_eff > EMB_WC_MAX) begin
      wc_eff = EMB_WC_MAX;
    end
    off = 12'(ram_addr_r[EMB_RAM_AW-1:0] << wc_eff);
    if (split) begin
      off[EMB_RAM_AW-1] = ram_addr_r[EMB_RADDR_HALF];
    end
    lmask = 32'((33'h000000001 << (6'h01 << wc_eff)) - 33'h000000001);
  end

  // RAM array; reset restores the configured pattern.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      for (int w = 0; w < EMB_RAM_WORDS; w++) begin
        ram_r[w] <= RAM_INIT[w*EMB_DW +: EMB_DW];
      end
    end else if (ram_wr_fire) begin
      ram_r[off[11:5]] <= (ram_r[off[11:5]] & ~(lmask << off[4:0])) |
                          ((avs_writedata & lmask) << off[4:0]);
    end
  end

  // Registered read port of the RAM.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      rdata_r <= 32'h00000000;
    end else if (ram_rd_fire) begin
      rdata_r <= (ram_r[off[11:5]] >> off[4:0]) & lmask;
    end
  end

  // CAM store; entries may be preloaded or written at run time.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      cam_key_r   <= CAM_INIT_KEY;
      cam_care_r  <= '1;
      cam_valid_r <= CAM_INIT_VALID;
    end else if (cam_wr_fire) begin
      cam_key_r[cam_idx_r]   <= avs_writedata;
      cam_care_r[cam_idx_r]  <= ~cam_mask_r;
      cam_valid_r[cam_idx_r] <= 1'b1;
    end
  end

  emb_cam_match #(
    .DEPTH (EMB_CAM_DEPTH),
    .WIDTH (EMB_DW)
  ) u_match (
    .keys       (cam_key_r),
    .cares      (cam_care_r),
    .valid      (cam_valid_r),
    .key        (avs_writedata),
    .ignore_msb (unenc),
    .hit        (hit)
  );

  // Fast mode spends the whole block on the low 16 entries.
  assign hit_eff = (mode == EMB_FAST) ? {16'h0000, hit[15:0]} : hit;

  // Lookup results: phase 0 shows entries 0-15, phase 1 entries 16-31.
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      flag_r  <= 1'b0;
      addr_r  <= 5'h00;
      lines_r <= 16'h0000;
      valid_r <= 1'b0;
      phase_r <= 1'b0;
      sel_r   <= 1'b0;
      key_r   <= 32'h00000000;
    end else if (look0) begin
      flag_r  <= |hit_eff;
      addr_r  <= (enc_ok && |hit_eff) ? emb_prio(hit_eff) : 5'h00;
      lines_r <= emb_bank(hit_eff[15:0], unenc, sel);
      valid_r <= !two_phase;
      phase_r <= 1'b0;
      sel_r   <= sel;
      key_r   <= avs_writedata;
    end else if (look1) begin
      lines_r <= emb_bank(hit_eff[31:16], unenc, sel);
      phase_r <= 1'b1;
      valid_r <= 1'b1;
    end
  end

  // Output stage with its own enable stands in for a separate clock.
  generate
    if (OUT_REG) begin : g_out_reg
      always_ff @(posedge clock or posedge arst) begin
        if (arst) begin
          match_flag   <= 1'b0;
          match_addr   <= 5'h00;
          match_lines  <= 16'h0000;
          result_valid <= 1'b0;
        end else if (ce && !ctrl_r[EMB_CTRL_FREEZE]) begin
          match_flag   <= flag_r;
          match_addr   <= addr_r;
          match_lines  <= lines_r;
          result_valid <= valid_r;
        end
      end
    end else begin : g_out_direct
      assign match_flag   = flag_r;
      assign match_addr   = addr_r;
      assign match_lines  = lines_r;
      assign result_valid = valid_r;
    end
  endgenerate

  // Status word and read mux; unmapped offsets read zero.
  always_comb begin
    status = 32'h00000000;
    status[4:0] = addr_r;
    status[EMB_ST_FLAG]  = flag_r;
    status[EMB_ST_VALID] = valid_r;
    status[EMB_ST_PHASE] = phase_r;
    status[EMB_ST_SEL]   = sel_r;
    case (avs_address)
      EMB_OFF_CTRL:      avs_readdata = 32'(ctrl_r);
      EMB_OFF_STATUS:    avs_readdata = status;
      EMB_OFF_RAM_ADDR:  avs_readdata = 32'(ram_addr_r);
      EMB_OFF_RAM_DATA:  avs_readdata = rdata_r;
      EMB_OFF_CAM_INDEX: avs_readdata = 32'(cam_idx_r);
      EMB_OFF_CAM_MASK:  avs_readdata = cam_mask_r;
      EMB_OFF_CAM_DATA:  avs_readdata = cam_key_r[cam_idx_r];
      EMB_OFF_CAM_KEY:   avs_readdata = key_r;
      EMB_OFF_CAM_LINES: avs_readdata = 32'(lines_r);
      default:           avs_readdata = 32'h00000000;
    endcase
  end

  default clocking @(posedge clock); endclocking
  default disable iff (arst);
  a_split_half: assert property (split |->
    off[11] == ram_addr_r[EMB_RADDR_HALF])
    else $error("split half select lost");
  a_shape_max: assert property (wc_eff <= (split ? 3'h4 : 3'h5))
    else $error("width code beyond shape table");
  a_flag_hit: assert property ((accept && kind == EMB_ACC_LOOKUP) |->
    flag_r == (|hit_eff))
    else $error("match flag disagrees with compare");
  a_enc_addr: assert property ((accept && kind == EMB_ACC_LOOKUP &&
    enc_ok && flag_r) |-> hit_eff[addr_r] &&
    ((hit_eff & ((32'h1 << addr_r) - 32'h1)) == '0))
    else $error("encoded address not lowest match");
  a_care_store: assert property (cam_wr_fire |=>
    cam_care_r[$past(cam_idx_r)] == ~$past(cam_mask_r))
    else $error("care mask not stored");
  a_write_two: assert property ((cam_wr_fire && cnt_r == 2'h1) ##1 ce
    |-> !avs_waitrequest)
    else $error("plain CAM write not two cycles");
  a_write_dc: assert property ((kind == EMB_ACC_CAM_WR && ce &&
    cnt_r == 2'h0 && cam_mask_r != '0) ##1 ce |->
    avs_waitrequest ##1 (!ce || avs_waitrequest))
    else $error("masked CAM write shorter than three cycles");
  a_fast_low: assert property ((look0 && mode == EMB_FAST &&
    hit[15:0] == 16'h0000) |=> !flag_r)
    else $error("fast mode reports upper entries");
  a_bank_sel: assert property ((unenc && $past(look0 || look1)) |->
    (lines_r & (sel_r ? EMB_EVEN_LINES : EMB_ODD_LINES)) == '0)
    else $error("unselected bank lines raised");
  a_no_match: assert property ((valid_r && !flag_r) |->
    addr_r == 5'h00 && lines_r == 16'h0000)
    else $error("result shown without a match");
  a_rom_hold: assert property ((ctrl_r[EMB_CTRL_ROM] &&
    kind == EMB_ACC_RAM_WR) |=>
    ram_r[$past(off[11:5])] == $past(ram_r[off[11:5]]))
    else $error("read-only table was written");
  c_hit_single: cover property (look0 && mode == EMB_SINGLE && |hit_eff);
  c_two_phase:  cover property (look1 && |hit_eff[31:16]);
  c_dc_write:   cover property (cam_wr_fire && cam_mask_r != '0);
  c_ram_read:   cover property (accept && kind == EMB_ACC_RAM_RD);
endmodule : emb_memory_block

// File: tb/emb_fabric_enc.sv
`timescale 1ns/10ps
// Fabric-side priority encoder fed by the one-hot match lines.
module emb_fabric_enc
  import emb_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clear,
  input  wire logic [EMB_LINES-1:0]  lines,
  output logic      [EMB_LINES-1:0]  seen_r,
  output logic      [EMB_CAM_IW-1:0] first
);
  // Collect every line raised while the phases of one lookup go by.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seen_r <= '0;
    end else if (clear) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_r | lines;
    end
  end

  // Lowest line wins, so duplicated keys resolve to one address.
  always_comb begin
    first = '0;
    for (int i = EMB_LINES - 1; i >= 0; i--) begin
      if (seen_r[i]) begin
        first = i[EMB_CAM_IW-1:0];
      end
    end
  end
endmodule : emb_fabric_enc

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import emb_pkg::*;
;
  logic                  clock;
  logic                  rst;
  logic                  ce;
  logic                  clr_local;
  logic                  clr_global;
  logic [EMB_AW-1:0]     avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [EMB_DW-1:0]     avs_writedata;
  logic [3:0]            avs_byteenable;
  logic [EMB_DW-1:0]     avs_readdata;
  logic                  avs_waitrequest;
  logic                  match_flag;
  logic [EMB_CAM_IW-1:0] match_addr;
  logic [EMB_LINES-1:0]  match_lines;
  logic                  result_valid;
  logic                  pclr;
  logic [EMB_LINES-1:0]  seen;
  logic [EMB_CAM_IW-1:0] first;
  int                    n_fail = 0;
  int                    checks = 0;

  emb_memory_block uut (.clock(clock), .rst(rst), .ce(ce),
    .clr_local(clr_local), .clr_global(clr_global),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .match_flag(match_flag),
    .match_addr(match_addr), .match_lines(match_lines),
    .result_valid(result_valid));

  emb_fabric_enc fab (.clock(clock), .rst(rst), .clear(pclr),
    .lines(match_lines), .seen_r(seen), .first(first));

  // Free-running 200 MHz clock.
  always #2.5 clock = ~clock;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One Avalon transfer: the request stands until the rising edge that sees
  // waitrequest low, read data is taken there, and an idle edge follows so
  // that back-to-back calls never reassign a strobe in one time step.
  task automatic bus(input logic wr, input logic [EMB_AW-1:0] a,
                     input logic [EMB_DW-1:0] d,
                     output logic [EMB_DW-1:0] q, output int w);
    w = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0) begin
      w++;
      @(posedge clock);
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [EMB_AW-1:0] a, input logic [EMB_DW-1:0] d,
                    input int lat);
    logic [EMB_DW-1:0] q;
    int                w;
    bus(1'h1, a, d, q, w);
    if (lat >= 0) begin
      chk("write wait", 32'(lat), 32'(w));
    end
  endtask : wr

  task automatic rd(input logic [EMB_AW-1:0] a, input logic [EMB_DW-1:0] e,
                    input int lat);
    logic [EMB_DW-1:0] q;
    int                w;
    bus(1'h0, a, '0, q, w);
    chk("read data", e, q);
    chk("read wait", 32'(lat), 32'(w));
  endtask : rd

  // Let the output stage take the result, then realign to a rising edge.
  task automatic settle();
    repeat (3) @(negedge clock);
    @(posedge clock);
  endtask : settle

  task automatic look(input logic [EMB_DW-1:0] key, input int lat,
                      input logic fl, input int ea);
    wr(EMB_OFF_CAM_KEY, key, lat);
    settle();
    chk("match flag", {31'h0, fl}, {31'h0, match_flag});
    chk("result valid", 32'h1, {31'h0, result_valid});
    if (ea >= 0) begin
      chk("match addr", 32'(ea), {27'h0, match_addr});
    end
  endtask : look

  // Multi-phase lookup judged through the fabric encoder; a miss first
  // flushes the lines of the previous lookup.
  task automatic mlook(input logic [EMB_DW-1:0] key,
                       input logic [15:0] es, input int ef);
    wr(EMB_OFF_CAM_KEY, 32'h7777_7777, -1);
    settle();
    pclr <= 1'h1;
    @(posedge clock);
    pclr <= 1'h0;
    wr(EMB_OFF_CAM_KEY, key, 2);
    settle();
    chk("lines seen", {16'h0, es}, {16'h0, seen});
    chk("encoded", 32'(ef), {27'h0, first});
  endtask : mlook

  task automatic t_reset();
    rd(EMB_OFF_CTRL, 32'h0, 0);
    rd(EMB_OFF_STATUS, 32'h0, 0);
    rd(6'h3C, 32'h0, 0);
  endtask : t_reset

  task automatic t_ram();
    wr(EMB_OFF_CTRL, 32'h0000_000A, 0);
    wr(EMB_OFF_RAM_ADDR, 32'h0000_0003, 0);
    wr(EMB_OFF_RAM_DATA, 32'hA5C3_0F96, -1);
    rd(EMB_OFF_RAM_DATA, 32'hA5C3_0F96, 1);
    wr(EMB_OFF_CTRL, 32'h0000_008A, 0);
    wr(EMB_OFF_RAM_DATA, 32'h0000_0000, -1);
    rd(EMB_OFF_RAM_DATA, 32'hA5C3_0F96, 1);
    wr(EMB_OFF_CTRL, 32'h0000_0009, 0);
    wr(EMB_OFF_RAM_DATA, 32'h0000_1234, -1);
    wr(EMB_OFF_RAM_ADDR, 32'h0000_1003, 0);
    wr(EMB_OFF_RAM_DATA, 32'h0000_5678, -1);
    rd(EMB_OFF_RAM_DATA, 32'h0000_5678, 1);
    wr(EMB_OFF_RAM_ADDR, 32'h0000_0003, 0);
    rd(EMB_OFF_RAM_DATA, 32'h0000_1234, 1);
    // Each cycle with the clock enable low adds one wait cycle.
    fork
      rd(EMB_OFF_RAM_DATA, 32'h0000_1234, 3);
      begin
        ce <= 1'h0;
        repeat (2) @(posedge clock);
        ce <= 1'h1;
      end
    join
  endtask : t_ram

  task automatic t_single();
    wr(EMB_OFF_CTRL, 32'h0000_0000, 0);
    wr(EMB_OFF_CAM_INDEX, 32'h0000_000C, 0);
    wr(EMB_OFF_CAM_DATA, 32'h0000_FA12, 2);
    look(32'h0000_FA12, 1, 1'h1, 12);
    look(32'h0000_FA13, 1, 1'h0, -1);
    wr(EMB_OFF_CAM_INDEX, 32'h0000_0007, 0);
    wr(EMB_OFF_CAM_MASK, 32'h0000_00FF, 0);
    wr(EMB_OFF_CAM_DATA, 32'h3C3C_0000, 3);
    wr(EMB_OFF_CAM_MASK, 32'h0000_0000, 0);
    look(32'h3C3C_00AB, 1, 1'h1, 7);
  endtask : t_single

  task automatic t_multi();
    wr(EMB_OFF_CTRL, 32'h0000_0010, 0);
    wr(EMB_OFF_CAM_INDEX, 32'h0000_0005, 0);
    wr(EMB_OFF_CAM_DATA, 32'h0123_4567, 2);
    wr(EMB_OFF_CAM_INDEX, 32'h0000_0006, 0);
    wr(EMB_OFF_CAM_DATA, 32'h0123_4567, 2);
    mlook(32'h0123_4567, 16'h0060, 5);
    wr(EMB_OFF_CTRL, 32'h0000_0050, 0);
    // Top key bit acts as the bank select, not as compared data.
    mlook(32'h8123_4567, 16'h0020, 5);
    mlook(32'h0123_4567, 16'h0040, 6);
    wr(EMB_OFF_CTRL, 32'h0000_0040, 0);
    mlook(32'h0000_FA12, 16'h1000, 12);
  endtask : t_multi

  task automatic t_fast();
    wr(EMB_OFF_CTRL, 32'h0000_0020, 0);
    wr(EMB_OFF_CAM_INDEX, 32'h0000_0014, 0);
    wr(EMB_OFF_CAM_DATA, 32'h0BAD_F00D, 2);
    look(32'h0BAD_F00D, 1, 1'h0, -1);
    look(32'h0123_4567, 1, 1'h1, 0);
  endtask : t_fast

  // A frozen output stage keeps showing the previous result.
  task automatic t_hold();
    wr(EMB_OFF_CTRL, 32'h0000_0100, 0);
    look(32'h0000_1111, 1, 1'h1, 0);
    wr(EMB_OFF_CTRL, 32'h0000_0000, 0);
    settle();
    chk("match flag", 32'h0, {31'h0, match_flag});
    look(32'h0000_FA12, 1, 1'h1, 12);
  endtask : t_hold

  task automatic t_clear();
    for (int i = 0; i < 3; i++) begin
      wr(EMB_OFF_CTRL, 32'h0000_000A, 0);
      if (i == 0) begin
        clr_local <= 1'h1;
      end else if (i == 1) begin
        clr_global <= 1'h1;
      end else begin
        rst <= 1'h1;
      end
      @(posedge clock);
      clr_local  <= 1'h0;
      clr_global <= 1'h0;
      rst        <= 1'h0;
      @(posedge clock);
      chk("flag cleared", 32'h0, {31'h0, match_flag});
      chk("valid cleared", 32'h0, {31'h0, result_valid});
      rd(EMB_OFF_CTRL, 32'h0, 0);
    end
  endtask : t_clear

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial begin
    clock          = 1'h0;
    rst            = 1'h1;
    ce             = 1'h1;
    clr_local      = 1'h0;
    clr_global     = 1'h0;
    pclr           = 1'h0;
    avs_address    = '0;
    avs_read       = 1'h0;
    avs_write      = 1'h0;
    avs_writedata  = '0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_reset();
    t_ram();
    t_single();
    t_multi();
    t_fast();
    t_hold();
    t_clear();
    give_verdict();
  end

  // The whole run needs well under a thousand cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
endmodule : tb_top
